// File: pkg/airc_pkg.sv
package airc_pkg;
    // ==========================================================
    // Channel modes
    typedef enum logic [3:0] {
        AIRC_MODE_OFF    = 4'h0,
        AIRC_MODE_V10    = 4'h1,
        AIRC_MODE_V5     = 4'h2,
        AIRC_MODE_V0_10  = 4'h3,
        AIRC_MODE_V0_5   = 4'h4,
        AIRC_MODE_I0_20  = 4'h5,
        AIRC_MODE_I4_20  = 4'h6,
        AIRC_MODE_PT400  = 4'h7,
        AIRC_MODE_PT70   = 4'h8,
        AIRC_MODE_DIFF10 = 4'h9,
        AIRC_MODE_DIFF5  = 4'hA
    } airc_mode_t;

    // ==========================================================
    // Result codes
    localparam logic signed [15:0] AIRC_OVF_CODE = 16'sh7FFF;
    localparam logic signed [15:0] AIRC_UNF_CODE = 16'sh8001;
    localparam logic signed [15:0] AIRC_FULL_POS = 16'sh7FF8;
    localparam logic signed [15:0] AIRC_FULL_NEG = 16'sh8008;
    // Plausibility margin, about 2.5 % of full scale
    localparam logic signed [16:0] AIRC_PLAUS_POS = 17'sh08333;
    localparam logic signed [16:0] AIRC_PLAUS_NEG = 17'sh17CCD;
    // Open circuit below about 3 mA on a 0..20 mA scale
    localparam logic signed [15:0] AIRC_OPEN_LIM  = 16'sh1333;
    // Pt100 ranges
    localparam logic signed [15:0] AIRC_PT_MIN    = 16'shFC02;
    localparam logic signed [15:0] AIRC_PT400_MAX = 16'sh1FFE;
    localparam logic signed [15:0] AIRC_PT70_MAX  = 16'sh0599;

    // ==========================================================
    // Error numbers within error class four
    localparam logic [7:0] AIRC_ERR_SHUNT = 8'h04;
    localparam logic [7:0] AIRC_ERR_OPEN  = 8'h09;
    localparam logic [7:0] AIRC_ERR_PLAUS = 8'h0A;

    // ==========================================================
    // Timing
    localparam int AIRC_CLK_HZ    = 125_000_000;
    localparam int AIRC_RETRY_MS  = 1000;
    localparam int AIRC_RETRY_CYC = AIRC_CLK_HZ / 1000 * AIRC_RETRY_MS;

    // ==========================================================
    // Register offsets and reset values
    localparam logic [3:0] AIRC_REG_MODE0  = 4'h0;
    localparam logic [3:0] AIRC_REG_MODE1  = 4'h1;
    localparam logic [3:0] AIRC_REG_MON    = 4'h2;
    localparam logic [3:0] AIRC_REG_STAT   = 4'h3;
    localparam logic [3:0] AIRC_REG_MASK   = 4'h4;
    localparam logic [3:0] AIRC_REG_ERR    = 4'h5;
    localparam logic [3:0] AIRC_REG_WORD0  = 4'h8;
    localparam logic [31:0] AIRC_MODE_RST  = 32'h0000_0000;
    localparam logic [15:0] AIRC_MON_RST   = 16'h0000;
    localparam logic [7:0]  AIRC_MASK_RST  = 8'h00;
endpackage : airc_pkg

// File: core/airc_checker.sv
// Function
// - Voltage range out of bounds gives saturation codes
// - Current range out of bounds gives saturation codes
// - Plausibility overshoot 2-3 percent logs error 10
// - Saturation codes substituted regardless of monitoring
// - Zero-to-twenty milliamp detects overflow only
// - Excess current switches shunt off, overflow code
// - Shunt reconnect retried about once per second
// - Shunt protection lights overload, logs error 4
// - Four-to-twenty below 3 mA is open circuit
// - Monitored open circuit lights overload, error 9
// - Differential result is high minus low channel
// - Differential result goes to odd channel word
// - Pt100 open gives overflow, short underflow
`timescale 1ns/1ns
module airc_checker #(
    parameter int N_CH      = 8,
    parameter int RETRY_CYC = airc_pkg::AIRC_RETRY_CYC
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst,
    input  wire logic                 i_conv_valid,
    input  wire logic [N_CH*16-1:0]   i_conv_data,
    input  wire logic [N_CH-1:0]      i_conv_ovr,
    input  wire logic [N_CH-1:0]      i_conv_unr,
    input  wire logic [N_CH-1:0]      i_shunt_excess,
    input  wire logic [N_CH-1:0]      i_pt_open,
    input  wire logic [N_CH-1:0]      i_pt_short,
    input  wire logic [3:0]           i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [31:0]          o_rdata,
    output logic      [N_CH-1:0]      o_shunt_on,
    output logic                      o_overload_led,
    output logic                      o_err_valid,
    output logic      [7:0]           o_err_num,
    output logic      [2:0]           o_err_ch,
    output logic                      o_irq
);
    import airc_pkg::*;

    // ==========================================================
    // Registers
    logic [31:0]        mode_lo;
    logic [31:0]        mode_hi;
    logic [15:0]        mon;        // [7:0] plausibility, [15:8] open
    logic [7:0]         stat;
    logic [7:0]         mask;
    logic [15:0]        word [N_CH];
    logic [N_CH-1:0]    shunt_off;
    logic [N_CH-1:0]    shunt_trip;
    logic [N_CH-1:0]    is_cur;
    logic [N_CH-1:0]    open_det;
    logic [N_CH-1:0]    plaus_det;
    logic [N_CH-1:0]    ev_plaus;
    logic [N_CH-1:0]    ev_open;
    logic [N_CH-1:0]    ev_shunt;
    logic [N_CH-1:0]    pend_plaus;
    logic [N_CH-1:0]    pend_open;
    logic [N_CH-1:0]    pend_shunt;
    logic [31:0]        retry_cnt;
    logic               retry_tick;
    logic signed [15:0] next_word [N_CH];
    logic [N_CH-1:0]    next_plaus;
    logic [N_CH-1:0]    next_open;
    logic [N_CH-1:0]    wr_stat;

    function automatic airc_mode_t ch_mode(input int c,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
        logic [63:0] all;
        all = {hi, lo};
        ch_mode = airc_mode_t'(all[c*4 +: 4]);
    endfunction : ch_mode

    // ==========================================================
    // Register writes
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            mode_lo <= AIRC_MODE_RST;
            mode_hi <= AIRC_MODE_RST;
            mon     <= AIRC_MON_RST;
            mask    <= AIRC_MASK_RST;
        end else if (i_wr) begin
            case (i_addr)
                AIRC_REG_MODE0: mode_lo <= i_wdata;
                AIRC_REG_MODE1: mode_hi <= i_wdata;
                AIRC_REG_MON:   mon     <= i_wdata[15:0];
                AIRC_REG_MASK:  mask    <= i_wdata[7:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // One-second retry divider
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            retry_cnt  <= '0;
            retry_tick <= 1'b0;
        end else if (retry_cnt == 32'(RETRY_CYC - 1)) begin
            retry_cnt  <= '0;
            retry_tick <= 1'b1;
        end else begin
            retry_cnt  <= retry_cnt + 32'h1;
            retry_tick <= 1'b0;
        end
    end

    // ==========================================================
    // Per-channel evaluation
    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            airc_mode_t          m;
            logic signed [15:0]  raw;
            logic signed [15:0]  low;
            logic signed [16:0]  diff;
            logic                is_i;
            logic                is_pt;
            logic                is_diff;
            logic signed [15:0]  pt_max;
            assign m       = ch_mode(g, mode_lo, mode_hi);
            assign raw     = i_conv_data[g*16 +: 16];
            assign low     = (g % 2 == 1) ? i_conv_data[(g-g%2)*16 +: 16]
                                          : 16'sh0000;
            assign diff    = {raw[15], raw} - {low[15], low};
            assign is_i    = (m == AIRC_MODE_I0_20) || (m == AIRC_MODE_I4_20);
            assign is_pt   = (m == AIRC_MODE_PT400) || (m == AIRC_MODE_PT70);
            assign is_diff = (m == AIRC_MODE_DIFF10) ||
                             (m == AIRC_MODE_DIFF5);
            assign pt_max  = (m == AIRC_MODE_PT400) ? AIRC_PT400_MAX
                                                    : AIRC_PT70_MAX;

            always_comb begin
                next_word[g]  = raw;
                next_plaus[g] = 1'b0;
                next_open[g]  = 1'b0;
                if (is_i && (shunt_off[g] || i_shunt_excess[g])) begin
                    next_word[g] = AIRC_OVF_CODE;
                end else if (is_pt && i_pt_open[g]) begin
                    next_word[g] = AIRC_OVF_CODE;
                    next_open[g] = 1'b1;
                end else if (is_pt && i_pt_short[g]) begin
                    next_word[g] = AIRC_UNF_CODE;
                    next_open[g] = 1'b1;
                end else if (m == AIRC_MODE_I4_20 &&
                             raw < AIRC_OPEN_LIM) begin
                    next_word[g] = AIRC_UNF_CODE;
                    next_open[g] = 1'b1;
                end else if (i_conv_ovr[g]) begin
                    next_word[g] = AIRC_OVF_CODE;
                end else if (i_conv_unr[g] && m != AIRC_MODE_I0_20) begin
                    next_word[g] = AIRC_UNF_CODE;
                end else if (is_pt && raw > pt_max) begin
                    next_word[g] = AIRC_OVF_CODE;
                end else if (is_pt && raw < AIRC_PT_MIN) begin
                    next_word[g] = AIRC_UNF_CODE;
                end else if (is_diff && g % 2 == 1) begin
                    if (diff > 17'sh07FFF) begin
                        next_word[g] = AIRC_OVF_CODE;
                    end else if (diff < 17'sh18001) begin
                        next_word[g] = AIRC_UNF_CODE;
                    end else begin
                        next_word[g] = diff[15:0];
                    end
                end
                // Word saturates short of the margin; converter flags it
                if (m != AIRC_MODE_OFF && !is_pt &&
                    (i_conv_ovr[g] ||
                     (i_conv_unr[g] && m != AIRC_MODE_I0_20))) begin
                    next_plaus[g] = mon[g];
                end
            end

            // Shunt self-protection with periodic retry
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    shunt_off[g] <= 1'b0;
                end else if (!is_i) begin
                    shunt_off[g] <= 1'b0;
                end else if (i_shunt_excess[g]) begin
                    shunt_off[g] <= 1'b1;
                end else if (retry_tick) begin
                    shunt_off[g] <= 1'b0;
                end
            end

            // Held across retry attempts so the indicator never blinks
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    shunt_trip[g] <= 1'b0;
                end else if (!is_i) begin
                    shunt_trip[g] <= 1'b0;
                end else if (i_shunt_excess[g]) begin
                    shunt_trip[g] <= 1'b1;
                end else if (!shunt_off[g]) begin
                    shunt_trip[g] <= 1'b0;
                end
            end

            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    word[g] <= 16'h0000;
                end else if (i_conv_valid) begin
                    word[g] <= next_word[g];
                end
            end

            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    open_det[g]  <= 1'b0;
                    plaus_det[g] <= 1'b0;
                end else if (i_conv_valid) begin
                    open_det[g]  <= next_open[g] && mon[8+g];
                    plaus_det[g] <= next_plaus[g];
                end
            end

            assign ev_plaus[g] = i_conv_valid && next_plaus[g] &&
                                 !plaus_det[g];
            assign ev_open[g]  = i_conv_valid && next_open[g] &&
                                 mon[8+g] && !open_det[g];
            assign ev_shunt[g] = is_i && i_shunt_excess[g] && !shunt_trip[g];
            assign is_cur[g]   = is_i;
            assign o_shunt_on[g] = !shunt_off[g];
        end
    endgenerate

    // Lit continuously during protection or monitored open circuit
    assign o_overload_led = (|shunt_trip) || (|open_det);

    // ==========================================================
    // Error reporter: one message per cycle, shunt first
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pend_plaus <= '0;
            pend_open  <= '0;
            pend_shunt <= '0;
            o_err_valid <= 1'b0;
            o_err_num   <= 8'h00;
            o_err_ch    <= 3'h0;
        end else begin
            logic [N_CH-1:0] ps;
            logic [N_CH-1:0] po;
            logic [N_CH-1:0] pp;
            ps = pend_shunt | ev_shunt;
            po = pend_open  | ev_open;
            pp = pend_plaus | ev_plaus;
            o_err_valid <= 1'b0;
            if (|ps) begin
                for (int c = N_CH - 1; c >= 0; c--) begin
                    if (ps[c]) begin
                        o_err_ch <= 3'(c);
                    end
                end
                ps = ps & (ps - 1'b1);
                o_err_valid <= 1'b1;
                o_err_num   <= AIRC_ERR_SHUNT;
            end else if (|po) begin
                for (int c = N_CH - 1; c >= 0; c--) begin
                    if (po[c]) begin
                        o_err_ch <= 3'(c);
                    end
                end
                po = po & (po - 1'b1);
                o_err_valid <= 1'b1;
                o_err_num   <= AIRC_ERR_OPEN;
            end else if (|pp) begin
                for (int c = N_CH - 1; c >= 0; c--) begin
                    if (pp[c]) begin
                        o_err_ch <= 3'(c);
                    end
                end
                pp = pp & (pp - 1'b1);
                o_err_valid <= 1'b1;
                o_err_num   <= AIRC_ERR_PLAUS;
            end
            pend_shunt <= ps;
            pend_open  <= po;
            pend_plaus <= pp;
        end
    end

    // ==========================================================
    // Sticky status: bit0 shunt, bit1 open, bit2 plausibility
    always_comb begin
        wr_stat = '0;
        if (i_wr && i_addr == AIRC_REG_STAT) begin
            wr_stat = i_wdata[N_CH-1:0];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            stat <= 8'h00;
        end else begin
            // Set wins over a simultaneous clear
            stat <= (stat & ~wr_stat[7:0]) |
                    {5'h00, |ev_plaus, |ev_open, |ev_shunt};
        end
    end

    assign o_irq = |(stat & mask);

    // ==========================================================
    // Read port
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                AIRC_REG_MODE0: o_rdata <= mode_lo;
                AIRC_REG_MODE1: o_rdata <= mode_hi;
                AIRC_REG_MON:   o_rdata <= {16'h0000, mon};
                AIRC_REG_STAT:  o_rdata <= {24'h000000, stat};
                AIRC_REG_MASK:  o_rdata <= {24'h000000, mask};
                AIRC_REG_ERR:   o_rdata <= {16'h0000, o_shunt_on,
                                            open_det};
                default: begin
                    if (i_addr >= AIRC_REG_WORD0) begin
                        o_rdata <= {16'h0000, word[i_addr[2:0]]};
                    end else begin
                        o_rdata <= 32'h0000_0000;
                    end
                end
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // Checks
    a_ovf_code: assert property (
        @(posedge i_clk_sys) disable iff (i_rst) i_conv_valid &&
        i_conv_ovr[0] && ch_mode(0, mode_lo, mode_hi) == AIRC_MODE_V10
        |=> word[0] == AIRC_OVF_CODE) else $error("overflow code missing");
    a_unf_code: assert property (
        @(posedge i_clk_sys) disable iff (i_rst) i_conv_valid &&
        i_conv_unr[0] && !i_conv_ovr[0] &&
        ch_mode(0, mode_lo, mode_hi) == AIRC_MODE_V5
        |=> word[0] == AIRC_UNF_CODE) else $error("underflow code missing");
    a_cur_ovf: assert property (
        @(posedge i_clk_sys) disable iff (i_rst) i_conv_valid &&
        i_conv_ovr[1] && ch_mode(1, mode_lo, mode_hi) == AIRC_MODE_I0_20
        |=> word[1] == AIRC_OVF_CODE) else $error("current overflow missing");
    a_i020_unf: assert property (
        @(posedge i_clk_sys) disable iff (i_rst) i_conv_valid &&
        i_conv_unr[1] && !i_conv_ovr[1] && !shunt_off[1] &&
        !i_shunt_excess[1] &&
        ch_mode(1, mode_lo, mode_hi) == AIRC_MODE_I0_20
        |=> word[1] == $past(i_conv_data[31:16]))
        else $error("underflow code in zero based range");
    a_shunt_cut: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_shunt_excess & is_cur) != '0 |=> o_overload_led &&
        (o_shunt_on & $past(i_shunt_excess & is_cur)) == '0)
        else $error("shunt not cut");
    a_led_open: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        |open_det |-> o_overload_led)
        else $error("led off during open circuit");
endmodule : airc_checker

// File: dv/airc_sensor_model.sv
`timescale 1ns/1ns
// ==========================================================
// Sensor side: converter results, and shunt current sensing
module airc_sensor_model #(
    parameter int N_CH = 8
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire logic [N_CH*16-1:0] i_val,
    input  wire logic [N_CH-1:0]   i_exc,
    input  wire logic [N_CH-1:0]   i_shunt_on,
    output logic                   o_conv_valid,
    output logic [N_CH*16-1:0]     o_conv_data,
    output logic [N_CH-1:0]        o_shunt_excess
);
    logic [1:0] cnt;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 2'h0;
            o_conv_valid <= 1'b0;
            o_conv_data <= '0;
        end else begin
            cnt <= cnt + 2'h1;
            o_conv_valid <= (cnt == 2'h3);
            // Outside the strobe the data are not held, so show junk
            o_conv_data <= (cnt == 2'h3) ? i_val : ~i_val;
        end
    end

    // No current is sensed through a shunt that is switched off
    assign o_shunt_excess = i_exc & i_shunt_on;
endmodule : airc_sensor_model

// File: dv/analog_input_range_checker_tb.sv
`timescale 1ns/1ns
module analog_input_range_checker_tb;
    import airc_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [127:0] val = '0;
    logic [7:0] ovr = '0, unr = '0, exc = '0, opn = '0, sht = '0;
    logic [3:0] addr = '0;
    logic [31:0] wdata = '0, d;
    logic wr = 1'b0, rd = 1'b0, cv;
    logic [127:0] cd;
    logic [7:0] sx, shunt_on, en, err_num;
    logic [31:0] rdata;
    logic led, ev, irq;
    logic [2:0] ec, err_ch;
    int mismatches = 0, cmp_count = 0, i;

    always #4 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (ev === 1'b1) begin
        en <= err_num;
        ec <= err_ch;
    end

    airc_sensor_model #(.N_CH(8)) snr (.i_clk_sys(i_clk_sys),
        .i_rst(i_rst), .i_val(val), .i_exc(exc), .i_shunt_on(shunt_on),
        .o_conv_valid(cv), .o_conv_data(cd), .o_shunt_excess(sx));

    airc_checker #(.N_CH(8), .RETRY_CYC(50)) dut (.i_clk_sys(i_clk_sys),
        .i_rst(i_rst), .i_conv_valid(cv), .i_conv_data(cd),
        .i_conv_ovr(ovr), .i_conv_unr(unr), .i_shunt_excess(sx),
        .i_pt_open(opn), .i_pt_short(sht), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_shunt_on(shunt_on), .o_overload_led(led), .o_err_valid(ev),
        .o_err_num(err_num), .o_err_ch(err_ch), .o_irq(irq));

    // ==========================================================
    // Shared tasks
    task automatic results;
        $display("checks=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tmo;
        mismatches++;
        results();
    endtask : tmo

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge i_clk_sys);
        wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk_sys);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : bus_rd

    // At least one conversion strobe must pass before the word is valid
    task automatic word(input int ch, input logic [15:0] exp);
        repeat (12) @(posedge i_clk_sys);
        bus_rd(AIRC_REG_WORD0 + 4'(ch), d);
        chk({16'h0, d[15:0]}, {16'h0, exp});
    endtask : word

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk({24'h0, shunt_on}, 32'h0000_00FF);
        chk({31'h0, irq}, 32'h0);
        bus_rd(AIRC_REG_MODE0, d); chk(d, AIRC_MODE_RST);
        bus_rd(AIRC_REG_MON, d); chk(d, {16'h0, AIRC_MON_RST});
        bus_rd(AIRC_REG_MASK, d); chk(d, {24'h0, AIRC_MASK_RST});
        bus_wr(4'h6, 32'hFFFF_FFFF);
        bus_rd(4'h6, d); chk(d, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_volt;
        val[15:0] <= 16'h1230;
        for (i = 1; i <= 4; i++) begin
            bus_wr(AIRC_REG_MODE0, 32'(i));
            ovr[0] <= 1'b1;
            word(0, AIRC_OVF_CODE);
            ovr[0] <= 1'b0;
            unr[0] <= 1'b1;
            word(0, AIRC_UNF_CODE);
            unr[0] <= 1'b0;
        end
        bus_wr(AIRC_REG_MODE0, 32'h1);
        word(0, 16'h1230);
        $display("test voltage done");
    endtask : t_volt

    task automatic t_curr;
        val[31:16] <= 16'h4000;
        bus_wr(AIRC_REG_MODE0, 32'h50);
        ovr[1] <= 1'b1;
        word(1, AIRC_OVF_CODE);
        ovr[1] <= 1'b0;
        unr[1] <= 1'b1;
        repeat (12) @(posedge i_clk_sys);
        bus_rd(4'h9, d);
        chk({16'h0, d[15:0]}, 32'h0000_4000);
        bus_wr(AIRC_REG_MODE0, 32'h60);
        word(1, AIRC_UNF_CODE);
        unr[1] <= 1'b0;
        bus_wr(AIRC_REG_MON, 32'h0000_0200);
        val[31:16] <= 16'h0100;
        word(1, AIRC_UNF_CODE);
        chk({31'h0, led}, 32'h1);
        chk({21'h0, ec, en}, {21'h0, 3'h1, AIRC_ERR_OPEN});
        val[31:16] <= 16'h4000;
        repeat (12) @(posedge i_clk_sys);
        chk({31'h0, led}, 32'h0);
        $display("test current done");
    endtask : t_curr

    task automatic t_shunt;
        bus_wr(AIRC_REG_MODE0, 32'h600);
        exc[2] <= 1'b1;
        for (i = 0; i < 20 && shunt_on[2] === 1'b1; i++)
            @(posedge i_clk_sys);
        if (shunt_on[2] !== 1'b0) tmo();
        word(2, AIRC_OVF_CODE);
        chk({31'h0, led}, 32'h1);
        chk({21'h0, ec, en}, {21'h0, 3'h2, AIRC_ERR_SHUNT});
        exc[2] <= 1'b0;
        for (i = 0; i < 120 && shunt_on[2] !== 1'b1; i++)
            @(posedge i_clk_sys);
        if (shunt_on[2] !== 1'b1) tmo();
        repeat (12) @(posedge i_clk_sys);
        chk({31'h0, led}, 32'h0);
        chk({24'h0, shunt_on}, 32'h0000_00FF);
        $display("test shunt done");
    endtask : t_shunt

    task automatic t_plaus;
        bus_wr(AIRC_REG_MODE0, 32'h1000);
        bus_wr(AIRC_REG_MON, 32'h0000_0008);
        val[63:48] <= 16'h7FFF;
        ovr[3] <= 1'b1;
        word(3, AIRC_OVF_CODE);
        chk({21'h0, ec, en}, {21'h0, 3'h3, AIRC_ERR_PLAUS});
        ovr[3] <= 1'b0;
        $display("test plausibility done");
    endtask : t_plaus

    task automatic t_diff;
        bus_wr(AIRC_REG_MODE0, 32'h0099_0000);
        val[95:64] <= {16'h3000, 16'h1000};
        word(5, 16'h2000);
        bus_wr(AIRC_REG_MODE0, 32'h00AA_0000);
        val[95:64] <= {16'h1000, 16'h3000};
        word(5, 16'hE000);
        $display("test differential done");
    endtask : t_diff

    task automatic t_pt;
        for (i = 7; i <= 8; i++) begin
            bus_wr(AIRC_REG_MODE0, 32'(i) << 24);
            opn[6] <= 1'b1;
            word(6, AIRC_OVF_CODE);
            opn[6] <= 1'b0;
            sht[6] <= 1'b1;
            word(6, AIRC_UNF_CODE);
            sht[6] <= 1'b0;
        end
        $display("test resistance done");
    endtask : t_pt

    task automatic t_irq;
        bus_wr(AIRC_REG_MASK, 32'h0);
        @(posedge i_clk_sys);
        chk({31'h0, irq}, 32'h0);
        bus_wr(AIRC_REG_MASK, 32'h7);
        @(posedge i_clk_sys);
        chk({31'h0, irq}, 32'h1);
        bus_rd(AIRC_REG_STAT, d);
        chk({29'h0, d[2:0]}, 32'h7);
        bus_wr(AIRC_REG_STAT, 32'h7);
        bus_rd(AIRC_REG_STAT, d);
        chk({29'h0, d[2:0]}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupt done");
    endtask : t_irq

    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_reset();
        t_volt();
        t_curr();
        t_shunt();
        t_plaus();
        t_diff();
        t_pt();
        t_irq();
        results();
    end

    initial begin
        #400_000;
        tmo();
    end
endmodule : analog_input_range_checker_tb
